// *** src/prs_pkg.sv ***
// Package for the pressure result and status register group.
// Assumes byte-wide registers reached through a serial register port.
`default_nettype none

package prs_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [7:0] PRS_ADDR_REF_LOW = 8'h15;
    localparam logic [7:0] PRS_ADDR_REF_MID = 8'h16;
    localparam logic [7:0] PRS_ADDR_REF_HIGH = 8'h17;
    localparam logic [7:0] PRS_ADDR_OFS_LOW = 8'h18;
    localparam logic [7:0] PRS_ADDR_OFS_HIGH = 8'h19;
    localparam logic [7:0] PRS_ADDR_POWER_MODE = 8'h1A;
    localparam logic [7:0] PRS_ADDR_EVENT_SRC = 8'h25;
    localparam logic [7:0] PRS_ADDR_QUEUE_STAT = 8'h26;
    localparam logic [7:0] PRS_ADDR_SAMPLE_STAT = 8'h27;
    localparam logic [7:0] PRS_ADDR_RES_LOW = 8'h28;
    localparam logic [7:0] PRS_ADDR_RES_MID = 8'h29;
    localparam logic [7:0] PRS_ADDR_RES_HIGH = 8'h2A;

    // ==========================================================
    // Field positions
    localparam int PRS_BIT_LOW_CURRENT = 0;
    localparam int PRS_BIT_RESERVED = 1;
    localparam int PRS_BIT_RELOAD_BUSY = 7;
    localparam int PRS_BIT_IRQ_ACTIVE = 2;
    localparam int PRS_BIT_PRESS_LOW = 1;
    localparam int PRS_BIT_PRESS_HIGH = 0;
    localparam int PRS_BIT_WATERMARK = 7;
    localparam int PRS_BIT_OVERRUN = 6;
    localparam int PRS_BIT_TEMP_OVERWRITE = 5;
    localparam int PRS_BIT_PRESS_OVERWRITE = 4;
    localparam int PRS_BIT_TEMP_NEW = 1;
    localparam int PRS_BIT_PRESS_NEW = 0;

    // ==========================================================
    // Widths and reset values
    localparam int PRS_FILL_W = 6;
    localparam int PRS_WTM_W = 5;
    localparam logic [23:0] PRS_REF_RESET = 24'h000000;
    localparam logic [15:0] PRS_OFS_RESET = 16'h0000;
    localparam logic [1:0] PRS_POWER_MODE_RESET = 2'h0;
    localparam logic [23:0] PRS_RESULT_RESET = 24'h000000;

endpackage : prs_pkg

`default_nettype wire

// *** src/prs_regs.sv ***
// Pressure result and status register group with a link-side access port.
// Assumes the serial interface logic runs on link_clk_i, issues one access at
// a time and keeps its clock running until link_done_o; sensor-side inputs
// come from logic on ref_clk_i.
// ==========================================================
// Summary of operation
// - Reference pressure is one signed 24-bit word over three bytes, low first.
// - Reference apply follows zero-capture or reference-refresh; the result also uses the reference with differential select on.
// - A signed 16-bit pressure offset sits in a low and a high byte.
// - Low-current select 0 means low-noise mode, 1 low-current; reset value 0.
// - Low-current select governs both single and continuous conversions.
// - Event source bit 7 reads 1 while the trim reload runs.
// - Event source bit 2 shows that one or more events occurred.
// - Bit 1 flags low differential event, bit 0 high differential event.
// - Queue status bit 7 is 1 when fill level is at or above threshold.
// - Queue status bit 6 flags a full queue with an overwritten sample.
// - Queue fill level is six bits, 0 empty, 32 full.
// - Bits 5 and 4 flag temperature and pressure results overwritten unread.
// - Bits 1 and 0 flag fresh temperature and pressure samples.
// - Sample status is refreshed every output-rate cycle.
// - Pressure result is a signed 24-bit word over three bytes, low first.
// - With all reference functions off, result is measured pressure minus offset.
// - Block update hold freezes the result until its high byte is read.
// - Watermark threshold comes from the five-bit watermark level field.
`timescale 1ns/1ps
`default_nettype none

module prs_regs
    import prs_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Link side, all on link_clk_i
    input wire logic link_clk_i,
    input wire logic link_req_i,
    input wire logic link_write_i,
    input wire logic [7:0] link_addr_i,
    input wire logic [7:0] link_wdata_i,
    output logic [7:0] link_rdata_o,
    output logic link_done_o,
    output logic link_busy_o,
    // Sensor side, all on ref_clk_i
    input wire logic press_sample_i,
    input wire logic [23:0] press_raw_i,
    input wire logic temp_sample_i,
    input wire logic temp_read_i,
    input wire logic trim_reload_busy_i,
    input wire logic pressure_low_event_i,
    input wire logic pressure_high_event_i,
    input wire logic zero_capture_function_i,
    input wire logic reference_refresh_function_i,
    input wire logic differential_select_i,
    input wire logic block_update_hold_i,
    input wire logic [PRS_WTM_W-1:0] watermark_level_i,
    input wire logic queue_overrun_i,
    input wire logic [PRS_FILL_W-1:0] queue_fill_level_i,
    output logic low_current_select_o,
    output logic reference_apply_o,
    output logic [23:0] reference_pressure_o,
    output logic [15:0] pressure_offset_o,
    output logic [23:0] pressure_result_word_o
);

    // ==========================================================
    // Reset release in both domains
    logic rst_sync1_reg;
    logic rst_sync2_reg;
    logic link_rst1_reg;
    logic link_rst2_reg;
    logic rst_n;
    logic link_rst_n;

    // Async assert, clocked release, so no flop leaves reset mid-edge
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end

    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_rst1_reg <= 1'b0;
            link_rst2_reg <= 1'b0;
        end else begin
            link_rst1_reg <= 1'b1;
            link_rst2_reg <= link_rst1_reg;
        end
    end

    assign rst_n = rst_sync2_reg;
    assign link_rst_n = link_rst2_reg;

    // ==========================================================
    // Link domain: request capture and answer return
    logic req_tgl_reg;
    logic req_write_reg;
    logic [7:0] req_addr_reg;
    logic [7:0] req_wdata_reg;
    logic busy_reg;
    logic done_reg;
    logic [7:0] rdata_reg;
    logic ack_sync1_reg;
    logic ack_sync2_reg;
    logic ack_seen_reg;
    logic ack_tgl_reg;
    logic [7:0] ans_data_reg;
    wire link_take = link_req_i && !busy_reg;
    wire link_ack = ack_sync2_reg != ack_seen_reg;

    // Address and data stay put until the answer returns, so the core may
    // sample them as stable words after seeing the toggle
    always_ff @(posedge link_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            req_tgl_reg <= 1'b0;
            req_write_reg <= 1'b0;
            req_addr_reg <= 8'h00;
            req_wdata_reg <= 8'h00;
            busy_reg <= 1'b0;
        end else if (link_take) begin
            req_tgl_reg <= ~req_tgl_reg;
            req_write_reg <= link_write_i;
            req_addr_reg <= link_addr_i;
            req_wdata_reg <= link_wdata_i;
            busy_reg <= 1'b1;
        end else if (link_ack) begin
            busy_reg <= 1'b0;
        end
    end

    // Answer toggle synchroniser; read data is stable once it is seen
    always_ff @(posedge link_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            ack_sync1_reg <= 1'b0;
            ack_sync2_reg <= 1'b0;
            ack_seen_reg <= 1'b0;
            done_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            ack_sync1_reg <= ack_tgl_reg;
            ack_sync2_reg <= ack_sync1_reg;
            ack_seen_reg <= ack_sync2_reg;
            done_reg <= link_ack;
            if (link_ack) begin
                rdata_reg <= ans_data_reg;
            end
        end
    end

    assign link_rdata_o = rdata_reg;
    assign link_done_o = done_reg;
    assign link_busy_o = busy_reg;

    // ==========================================================
    // Core domain: request detection
    logic req_sync1_reg;
    logic req_sync2_reg;
    logic req_seen_reg;
    wire req_new = req_sync2_reg != req_seen_reg;
    wire acc_en = ce_i && req_new;
    wire wr_en = acc_en && req_write_reg;
    wire rd_en = acc_en && !req_write_reg;

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            req_sync1_reg <= 1'b0;
            req_sync2_reg <= 1'b0;
            req_seen_reg <= 1'b0;
        end else if (ce_i) begin
            req_sync1_reg <= req_tgl_reg;
            req_sync2_reg <= req_sync1_reg;
            req_seen_reg <= req_sync2_reg;
        end
    end

    // Address decode
    wire hit_ref_low = req_addr_reg == PRS_ADDR_REF_LOW;
    wire hit_ref_mid = req_addr_reg == PRS_ADDR_REF_MID;
    wire hit_ref_high = req_addr_reg == PRS_ADDR_REF_HIGH;
    wire hit_ofs_low = req_addr_reg == PRS_ADDR_OFS_LOW;
    wire hit_ofs_high = req_addr_reg == PRS_ADDR_OFS_HIGH;
    wire hit_power = req_addr_reg == PRS_ADDR_POWER_MODE;
    wire hit_event = req_addr_reg == PRS_ADDR_EVENT_SRC;
    wire hit_queue = req_addr_reg == PRS_ADDR_QUEUE_STAT;
    wire hit_status = req_addr_reg == PRS_ADDR_SAMPLE_STAT;
    wire hit_res_low = req_addr_reg == PRS_ADDR_RES_LOW;
    wire hit_res_mid = req_addr_reg == PRS_ADDR_RES_MID;
    wire hit_res_high = req_addr_reg == PRS_ADDR_RES_HIGH;

    // ==========================================================
    // Writable registers
    logic [23:0] ref_reg;
    logic [15:0] ofs_reg;
    logic [1:0] power_mode_reg;

    // Only the low-current bit and the reserved bit are held; upper bits
    // are expected as zero and read back as zero
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ref_reg <= PRS_REF_RESET;
            ofs_reg <= PRS_OFS_RESET;
            power_mode_reg <= PRS_POWER_MODE_RESET;
        end else if (wr_en) begin
            if (hit_ref_low) ref_reg[7:0] <= req_wdata_reg;
            if (hit_ref_mid) ref_reg[15:8] <= req_wdata_reg;
            if (hit_ref_high) ref_reg[23:16] <= req_wdata_reg;
            if (hit_ofs_low) ofs_reg[7:0] <= req_wdata_reg;
            if (hit_ofs_high) ofs_reg[15:8] <= req_wdata_reg;
            if (hit_power) power_mode_reg <= req_wdata_reg[1:0];
        end
    end

    // Mode applies to every conversion; host only flips it powered down
    assign low_current_select_o = power_mode_reg[PRS_BIT_LOW_CURRENT];
    assign reference_pressure_o = ref_reg;
    assign pressure_offset_o = ofs_reg;
    assign reference_apply_o = zero_capture_function_i || reference_refresh_function_i;

    // ==========================================================
    // Pressure result with block update hold
    logic [23:0] result_reg;
    logic hold_reg;
    wire read_res_high = rd_en && hit_res_high;
    wire [23:0] ofs_ext = {{8{ofs_reg[15]}}, ofs_reg};
    wire use_plain_ofs = !differential_select_i && !reference_apply_o;
    // Reference functions compare against the stored reference instead
    wire [23:0] result_next = use_plain_ofs ? press_raw_i - ofs_ext
                                            : press_raw_i - ref_reg;
    wire result_load = ce_i && press_sample_i && !hold_reg;

    // Hold keeps the three bytes from one sample until the high byte goes
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            result_reg <= PRS_RESULT_RESET;
            hold_reg <= 1'b0;
        end else if (ce_i) begin
            if (result_load) result_reg <= result_next;
            if (result_load && block_update_hold_i) begin
                hold_reg <= 1'b1;
            end else if (read_res_high || !block_update_hold_i) begin
                hold_reg <= 1'b0;
            end
        end
    end

    assign pressure_result_word_o = result_reg;

    // ==========================================================
    // Sticky event and sample flags; a set in the clearing cycle wins
    logic press_low_reg;
    logic press_high_reg;
    logic press_new_reg;
    logic temp_new_reg;
    logic press_over_reg;
    logic temp_over_reg;
    wire read_event = rd_en && hit_event;
    wire read_status = rd_en && hit_status;
    wire press_set = press_sample_i;
    wire temp_set = temp_sample_i;

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            press_low_reg <= 1'b0;
            press_high_reg <= 1'b0;
        end else if (ce_i) begin
            press_low_reg <= pressure_low_event_i || (press_low_reg && !read_event);
            press_high_reg <= pressure_high_event_i || (press_high_reg && !read_event);
        end
    end

    // Refreshed on each output-rate sample strobe
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            press_new_reg <= 1'b0;
            temp_new_reg <= 1'b0;
            press_over_reg <= 1'b0;
            temp_over_reg <= 1'b0;
        end else if (ce_i) begin
            press_new_reg <= press_set || (press_new_reg && !read_res_high);
            temp_new_reg <= temp_set || (temp_new_reg && !temp_read_i);
            press_over_reg <= (press_set && press_new_reg) ||
                              (press_over_reg && !read_status);
            temp_over_reg <= (temp_set && temp_new_reg) ||
                             (temp_over_reg && !read_status);
        end
    end

    // ==========================================================
    // Read data assembly; unused bits and unmapped addresses read zero
    wire [7:0] event_byte = {trim_reload_busy_i, 4'h0,
                             press_low_reg || press_high_reg,
                             press_low_reg, press_high_reg};
    wire [4:0] fill_clip = queue_fill_level_i[PRS_FILL_W-1] ? 5'h1F
                                                            : queue_fill_level_i[4:0];
    wire wtm_hit = queue_fill_level_i[PRS_FILL_W-1] ||
                   (fill_clip >= watermark_level_i);
    wire [7:0] queue_byte = {wtm_hit, queue_overrun_i, queue_fill_level_i};
    wire [7:0] status_byte = {2'h0, temp_over_reg, press_over_reg,
                              2'h0, temp_new_reg, press_new_reg};
    wire [7:0] power_byte = {6'h00, power_mode_reg};

    logic [7:0] read_mux;

    // One-hot address hits select the answer byte
    always_comb begin
        read_mux = 8'h00;
        if (hit_ref_low) read_mux = ref_reg[7:0];
        if (hit_ref_mid) read_mux = ref_reg[15:8];
        if (hit_ref_high) read_mux = ref_reg[23:16];
        if (hit_ofs_low) read_mux = ofs_reg[7:0];
        if (hit_ofs_high) read_mux = ofs_reg[15:8];
        if (hit_power) read_mux = power_byte;
        if (hit_event) read_mux = event_byte;
        if (hit_queue) read_mux = queue_byte;
        if (hit_status) read_mux = status_byte;
        if (hit_res_low) read_mux = result_reg[7:0];
        if (hit_res_mid) read_mux = result_reg[15:8];
        if (hit_res_high) read_mux = result_reg[23:16];
    end

    // ==========================================================
    // Answer: data captured and toggle returned in the same edge
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ans_data_reg <= 8'h00;
            ack_tgl_reg <= 1'b0;
        end else if (acc_en) begin
            ans_data_reg <= req_write_reg ? 8'h00 : read_mux;
            ack_tgl_reg <= ~ack_tgl_reg;
        end
    end

endmodule : prs_regs

`default_nettype wire

// *** verification/prs_regs_props.sv ***
// Port-level assertions for the pressure register group.
// Assumes it is bound to prs_regs and that the link clock only runs around accesses.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Checker
module prs_regs_props (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic link_clk_i,
    input wire logic link_req_i,
    input wire logic link_busy_o,
    input wire logic link_done_o,
    input wire logic press_sample_i,
    input wire logic [23:0] press_raw_i,
    input wire logic zero_capture_function_i,
    input wire logic reference_refresh_function_i,
    input wire logic differential_select_i,
    input wire logic block_update_hold_i,
    input wire logic low_current_select_o,
    input wire logic reference_apply_o,
    input wire logic [23:0] reference_pressure_o,
    input wire logic [15:0] pressure_offset_o,
    input wire logic [23:0] pressure_result_word_o
);
    // Helpers: sign-extended offset, any reference function on, and hold off
    wire [23:0] ofs_ext = {{8{pressure_offset_o[15]}}, pressure_offset_o};
    wire fn_on = zero_capture_function_i | reference_refresh_function_i | differential_select_i;
    wire hold_off = !block_update_hold_i;

    a_apply_follows: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reference_apply_o == (zero_capture_function_i | reference_refresh_function_i))
        else $error("reference apply does not follow the functions");
    a_result_offset: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && press_sample_i && !fn_on && hold_off && !$past(block_update_hold_i)
        |=> pressure_result_word_o == $past(press_raw_i) - $past(ofs_ext))
        else $error("result is not raw minus offset");
    a_result_ref: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && press_sample_i && fn_on && hold_off && !$past(block_update_hold_i)
        |=> pressure_result_word_o == $past(press_raw_i) - $past(reference_pressure_o))
        else $error("result is not raw minus reference");
    a_result_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !$stable(pressure_result_word_o) |-> $past(press_sample_i) && $past(ce_i))
        else $error("result changed without a sample");
    a_cfg_written: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        !$stable({reference_pressure_o, pressure_offset_o, low_current_select_o})
        |-> $past(link_busy_o) || $past(link_req_i))
        else $error("configuration changed without an access");
    a_done_pulse: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        link_done_o |=> !link_done_o)
        else $error("done longer than one cycle");
    a_busy_done: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        $fell(link_busy_o) |-> link_done_o)
        else $error("busy fell without done");
    a_req_answer: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        link_req_i && !link_busy_o |=> link_busy_o ##[2:10] link_done_o)
        else $error("access not answered in time");
endmodule : prs_regs_props

bind prs_regs prs_regs_props chk_u (.ref_clk_i, .rst_n_i, .ce_i, .link_clk_i, .link_req_i,
    .link_busy_o, .link_done_o, .press_sample_i, .press_raw_i, .zero_capture_function_i,
    .reference_refresh_function_i, .differential_select_i, .block_update_hold_i,
    .low_current_select_o, .reference_apply_o, .reference_pressure_o, .pressure_offset_o,
    .pressure_result_word_o);
`default_nettype wire

// *** verification/prs_host_model.sv ***
// Host model on the link register port; owns the gated link clock.
// Assumes the testbench calls access() one at a time.
`timescale 1ns/1ps
`default_nettype none

module prs_host_model
    import prs_pkg::*;
(
    output logic link_clk_o,
    output logic link_req_o,
    output logic link_write_o,
    output logic [7:0] link_addr_o,
    output logic [7:0] link_wdata_o,
    input wire logic [7:0] link_rdata_i,
    input wire logic link_done_i
);
    logic run = 1'b1;
    int slow = 0;

    // ==========================================================
    // Link clock: 30 ns, stops low between accesses, offset from the core clock
    initial begin
        link_clk_o = 1'b0;
        link_req_o = 1'b0;
        link_write_o = 1'b0;
        link_addr_o = 8'h00;
        link_wdata_o = 8'h00;
        #3;
        forever #15 if (run || link_clk_o) link_clk_o = ~link_clk_o;
    end

    // ==========================================================
    // One access: pulse the request, hold the qualifiers until done
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        q = 8'hXX;
        run = 1'b1;
        repeat (slow + 3) @(posedge link_clk_o);
        link_req_o <= 1'b1;
        link_write_o <= wr;
        link_addr_o <= a;
        link_wdata_o <= d;
        @(posedge link_clk_o);
        link_req_o <= 1'b0;
        for (int n = 0; n < 16 && link_done_i !== 1'b1; n++) @(posedge link_clk_o);
        if (link_done_i === 1'b1) q = link_rdata_i;
        // Released lines no longer show the last value
        link_write_o <= ~wr;
        link_addr_o <= ~a;
        link_wdata_o <= ~d;
        run = 1'b0;
    endtask : access

    // Read-modify-write keeps the reserved bit, upper bits written 0
    task automatic set_low_current(input logic lc);
        logic [7:0] q;
        access(1'b0, PRS_ADDR_POWER_MODE, 8'h00, q);
        access(1'b1, PRS_ADDR_POWER_MODE, {6'h00, q[1], lc}, q);
    endtask : set_low_current
endmodule : prs_host_model
`default_nettype wire

// *** verification/test_prs_regs.sv ***
// Self-checking bench for the pressure register group against a reference model.
// Assumes the checker binds itself and the host model drives the link port.
`timescale 1ns/1ps
`default_nettype none

module test_prs_regs
    import prs_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic link_clk, link_req, link_write, link_done, link_busy, lc_o, app_o;
    logic [7:0] link_addr, link_wdata, link_rdata, q, d;
    logic ps = 1'b0, ts = 1'b0, tr = 1'b0, trim = 1'b0, pl = 1'b0, ph = 1'b0, o;
    logic zc = 1'b0, rr = 1'b0, df = 1'b0, block_update_hold = 1'b0, queue_overrun_flag = 1'b0, m_held = 1'b0;
    logic [23:0] raw = '0, ref_o, res_o, m_ref = '0, m_res = '0;
    logic [15:0] ofs_o, m_ofs = '0;
    logic [4:0] watermark_level = '0, w;
    logic [5:0] fill = '0, f;
    logic [7:0] zero_a [12] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h25, 8'h27,
                               8'h28, 8'h29, 8'h2A, 8'h40};
    int error_cnt = 0, checked = 0, cyc = 0;

    // Core clock, 100 MHz
    always #5 ref_clk_i = ~ref_clk_i;

    prs_host_model host_u (.link_clk_o(link_clk), .link_req_o(link_req),
        .link_write_o(link_write), .link_addr_o(link_addr), .link_wdata_o(link_wdata),
        .link_rdata_i(link_rdata), .link_done_i(link_done));
    prs_regs dut_u (.ref_clk_i, .rst_n_i, .ce_i, .link_clk_i(link_clk), .link_req_i(link_req),
        .link_write_i(link_write), .link_addr_i(link_addr), .link_wdata_i(link_wdata),
        .link_rdata_o(link_rdata), .link_done_o(link_done), .link_busy_o(link_busy),
        .press_sample_i(ps), .press_raw_i(raw), .temp_sample_i(ts), .temp_read_i(tr),
        .trim_reload_busy_i(trim), .pressure_low_event_i(pl), .pressure_high_event_i(ph),
        .zero_capture_function_i(zc), .reference_refresh_function_i(rr),
        .differential_select_i(df), .block_update_hold_i(block_update_hold), .watermark_level_i(watermark_level),
        .queue_overrun_i(queue_overrun_flag), .queue_fill_level_i(fill), .low_current_select_o(lc_o),
        .reference_apply_o(app_o), .reference_pressure_o(ref_o), .pressure_offset_o(ofs_o),
        .pressure_result_word_o(res_o));

    // ==========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host_u.access(1'b0, a, 8'h00, q);
        chk($sformatf("register %h", a), {16'h0000, q}, {16'h0000, e});
    endtask : rdchk

    // Sample in, model updates unless held or frozen, compare the word
    task automatic samp(input logic [23:0] r);
        @(posedge ref_clk_i);
        ps <= 1'b1;
        raw <= r;
        @(posedge ref_clk_i);
        ps <= 1'b0;
        raw <= ~r;
        if (!m_held && ce_i) m_res = r - ((zc | rr | df) ? m_ref : {{8{m_ofs[15]}}, m_ofs});
        m_held = m_held | block_update_hold;
        @(posedge ref_clk_i);
        chk("result word", res_o, m_res);
    endtask : samp

    // One-cycle strobe: 0 temp sample, 1 temp read, 2 low event, 3 high event
    task automatic strobe(input int k);
        @(posedge ref_clk_i);
        {ph, pl, tr, ts} <= 4'h1 << k;
        @(posedge ref_clk_i);
        {ph, pl, tr, ts} <= 4'h0;
    endtask : strobe

    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report

    // Hang guard, far above the expected run length
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            final_report;
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(48));
        repeat (10) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (20) @(posedge ref_clk_i);
        foreach (zero_a[i]) rdchk(zero_a[i], 8'h00);
        for (int i = 0; i < 5; i++) begin
            d = 8'($urandom);
            host_u.access(1'b1, PRS_ADDR_REF_LOW + 8'(i), d, q);
            if (i < 3) m_ref[8*i +: 8] = d;
            else m_ofs[8*(i-3) +: 8] = d;
        end
        host_u.slow = 2;
        for (int i = 0; i < 5; i++) rdchk(PRS_ADDR_REF_LOW + 8'(i),
            (i < 3) ? m_ref[8*i +: 8] : m_ofs[8*(i-3) +: 8]);
        host_u.slow = 0;
        chk("reference", ref_o, m_ref);
        chk("offset", {8'h00, ofs_o}, {8'h00, m_ofs});
        host_u.set_low_current(1'b1);
        chk("low current", {23'h000000, lc_o}, 24'h000001);
        rdchk(PRS_ADDR_POWER_MODE, 8'h01);
        host_u.set_low_current(1'b0);
        chk("low current", {23'h000000, lc_o}, 24'h000000);
        host_u.access(1'b1, PRS_ADDR_RES_LOW, 8'hA5, q);
        host_u.access(1'b1, 8'h40, 8'h5A, q);
        rdchk(PRS_ADDR_RES_LOW, 8'h00);
        rdchk(8'h40, 8'h00);
        // Back-to-back samples, then flags and result bytes
        repeat (3) samp(24'($urandom));
        strobe(0);
        strobe(0);
        rdchk(PRS_ADDR_SAMPLE_STAT, 8'h33);
        rdchk(PRS_ADDR_SAMPLE_STAT, 8'h03);
        for (int i = 0; i < 3; i++) rdchk(PRS_ADDR_RES_LOW + 8'(i), m_res[8*i +: 8]);
        strobe(1);
        rdchk(PRS_ADDR_SAMPLE_STAT, 8'h00);
        // Each reference function in turn
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk_i);
            {df, rr, zc} <= 3'h1 << k;
            @(posedge ref_clk_i);
            chk("apply", {23'h000000, app_o}, {23'h000000, k < 2});
            samp(24'($urandom));
        end
        {df, rr, zc} <= 3'h0;
        // Hold: second sample dropped until the high byte is read
        block_update_hold <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        repeat (2) samp(24'($urandom));
        rdchk(PRS_ADDR_RES_HIGH, m_res[23:16]);
        m_held = 1'b0;
        samp(24'($urandom));
        block_update_hold <= 1'b0;
        m_held = 1'b0;
        ce_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        samp(24'($urandom));
        ce_i <= 1'b1;
        // Event flags with the reload running
        trim <= 1'b1;
        for (int k = 2; k < 4; k++) begin
            strobe(k);
            rdchk(PRS_ADDR_EVENT_SRC, (k == 2) ? 8'h86 : 8'h85);
            rdchk(PRS_ADDR_EVENT_SRC, 8'h80);
        end
        @(posedge ref_clk_i);
        trim <= 1'b0;
        rdchk(PRS_ADDR_EVENT_SRC, 8'h00);
        // Queue status, boundaries first
        for (int i = 0; i < 6; i++) begin
            w = 5'($urandom);
            f = (i == 0) ? 6'h20 : (i == 1) ? {1'b0, w} : 6'($urandom_range(32));
            o = (f == 6'h20) & 1'($urandom);
            @(posedge ref_clk_i);
            fill <= f;
            watermark_level <= w;
            queue_overrun_flag <= o;
            rdchk(PRS_ADDR_QUEUE_STAT, {f >= {1'b0, w}, o, f});
        end
        final_report;
    end
endmodule : test_prs_regs
`default_nettype wire
